// ==== core/backlash_compensation_adder.sv ====
// Purpose: Adds a filtered, direction-selective backlash offset to the position reference.
// Assumes: Mode, motor, servo and reference inputs come from logic on CLK.
// Notes:   Settings are staged and only take over after a latch begun at rest, except direction, which takes over on restart.
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
module backlash_compensation_adder
   import backlash_pkg::*;
(
   input  wire logic                      CLK,
   input  wire logic                      RESET,
   input  wire logic                      PSEL,
   input  wire logic                      PENABLE,
   input  wire logic                      PWRITE,
   input  wire logic [backlash_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]               PWDATA,
   output logic      [31:0]               PRDATA,
   output logic                           PREADY,
   output logic                           PSLVERR,
   input  wire logic                      POS_CONTROL_MODE,
   input  wire logic                      ROTARY_MOTOR,
   input  wire logic                      SERVO_ON,
   input  wire logic                      MOTOR_STOPPED,
   input  wire logic                      REF_VALID,
   input  wire logic signed [31:0]        REF_POS,
   output logic signed [31:0]             CMD_POS,
   output logic                           COMP_ACTIVE
);
   import backlash_pkg::*;

   // Staged settings written by software
   logic                       backlash_direction_select_ff;
   logic signed [AMOUNT_W-1:0] backlash_offset_amount_ff;
   logic [TC_W-1:0]            backlash_lag_time_constant_ff;
   logic [RATIO_W-1:0]         num_ff;
   logic [RATIO_W-1:0]         den_ff;
   logic [31:0]                limit_ff;
   logic                       pending_ff;
   // Settings in force
   logic                       dir_act_ff;
   logic signed [31:0]         pulses_act_ff;
   logic [DIV_W-1:0]           gain_act_ff;
   logic                       bypass_act_ff;
   logic                       skip_ff;
   logic                       amt_neg_ff;
   logic                       amt_skip_ff;
   latch_state_e               state_ff;
   // Datapath
   logic signed [31:0]         last_ref_ff;
   logic signed [31:0]         target_ff;
   logic signed [55:0]         lag_ff;
   logic signed [31:0]         cmd_ff;
   logic [31:0]                prdata_ff;

   // APB decode
   wire        setup_rd = PSEL && !PENABLE && !PWRITE;
   wire        wr_acc   = PSEL && PENABLE && PWRITE;
   wire        hit_ctrl = PADDR == OFF_CTRL;
   wire        hit_amt  = PADDR == OFF_AMOUNT;
   wire        hit_tc   = PADDR == OFF_LAG_TC;
   wire        hit_num  = PADDR == OFF_NUM;
   wire        hit_den  = PADDR == OFF_DEN;
   wire        hit_lim  = PADDR == OFF_LIMIT;
   wire        hit_st   = PADDR == OFF_STATUS;
   wire        hit_comp = PADDR == OFF_COMP;
   wire        mapped   = hit_ctrl | hit_amt | hit_tc | hit_num | hit_den
                          | hit_lim | hit_st | hit_comp;
   wire signed [31:0] wdata_s  = PWDATA;
   wire        amt_in_range = (wdata_s >= AMOUNT_MIN) && (wdata_s <= AMOUNT_MAX);
   wire        wr_amt   = wr_acc && hit_amt && amt_in_range;
   wire        wr_tc    = wr_acc && hit_tc;
   wire        wr_num   = wr_acc && hit_num && (PWDATA[RATIO_W-1:0] != '0);
   wire        wr_den   = wr_acc && hit_den && (PWDATA[RATIO_W-1:0] != '0);
   wire        wr_lim   = wr_acc && hit_lim;
   wire        wr_dir   = wr_acc && hit_ctrl;
   wire        restart  = wr_dir && PWDATA[CTRL_RESTART_BIT];
   wire        set_pend = wr_amt | wr_tc | wr_num | wr_den | wr_lim;

   // Reference motion direction
   wire signed [31:0] delta    = REF_POS - last_ref_ff;
   wire        moving   = REF_VALID && (delta != 32'sh0);
   wire        fwd_move = moving && !delta[31];
   wire        rev_move = moving && delta[31];
   wire        comp_dir_move = dir_act_ff ? rev_move : fwd_move;
   wire        opp_dir_move  = dir_act_ff ? fwd_move : rev_move;
   wire        enabled  = POS_CONTROL_MODE && ROTARY_MOTOR && SERVO_ON;
   wire        at_rest  = !moving && MOTOR_STOPPED;

   // Conversion: |amount| * num / (10 * den), fraction dropped
   wire [AMOUNT_W-1:0] amt_abs = backlash_offset_amount_ff[AMOUNT_W-1]
                                 ? AMOUNT_W'(-backlash_offset_amount_ff)
                                 : backlash_offset_amount_ff;
   wire [DIV_W-1:0] conv_dividend = DIV_W'(amt_abs) * DIV_W'(num_ff);
   wire [DIV_W-1:0] conv_divisor  = DIV_W'(den_ff) * DIV_W'(TENTHS_PER_UNIT);
   // Lag gain in Q24: 2^24 / (tc * cycles per step)
   wire [DIV_W-1:0] gain_dividend = DIV_W'(1) << FRAC_W;
   wire [DIV_W-1:0] gain_divisor  = DIV_W'(backlash_lag_time_constant_ff)
                                    * DIV_W'(CYC_PER_TC);
   wire             start_div = state_ff == LATCH_START;
   wire [DIV_W-1:0] conv_q;
   wire [DIV_W-1:0] gain_q;
   wire             conv_done;
   wire             conv_busy;

   backlash_divider #(.WIDTH(DIV_W)) u_conv_div (
      .CLK      (CLK),
      .RESET    (RESET),
      .START    (start_div),
      .DIVIDEND (conv_dividend),
      .DIVISOR  (conv_divisor),
      .BUSY     (conv_busy),
      .DONE     (conv_done),
      .QUOTIENT (conv_q)
   );

   backlash_divider #(.WIDTH(DIV_W)) u_gain_div (
      .CLK      (CLK),
      .RESET    (RESET),
      .START    (start_div),
      .DIVIDEND (gain_dividend),
      .DIVISOR  (gain_divisor),
      .BUSY     (),
      .DONE     (),
      .QUOTIENT (gain_q)
   );

   // Both dividers share start and length, so one done covers both
   wire signed [31:0] conv_mag    = 32'(conv_q[30:0]);
   wire signed [31:0] nxt_pulses  = amt_neg_ff ? -conv_mag : conv_mag;

   // Skip when amount exceeds the speed-derived limit
   wire        over_limit = 32'(amt_abs) > limit_ff;

   latch_state_e nxt_state;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         LATCH_IDLE:  if (pending_ff && at_rest) nxt_state = LATCH_START;
         LATCH_START: nxt_state = LATCH_WAIT;
         LATCH_WAIT:  if (conv_done) nxt_state = LATCH_IDLE;
         default:     nxt_state = LATCH_IDLE;
      endcase
   end

   // Settings registers; a write in the latch cycle keeps pending set
   always_ff @(posedge CLK) begin
      if (RESET) begin
         backlash_direction_select_ff  <= RST_DIR;
         backlash_offset_amount_ff     <= RST_AMOUNT;
         backlash_lag_time_constant_ff <= RST_TC;
         num_ff     <= RST_NUM;
         den_ff     <= RST_DEN;
         limit_ff   <= RST_LIMIT;
         pending_ff <= 1'b0;
      end else begin
         if (wr_dir) backlash_direction_select_ff <= PWDATA[CTRL_DIR_BIT];
         if (wr_amt) backlash_offset_amount_ff <= PWDATA[AMOUNT_W-1:0];
         if (wr_tc)  backlash_lag_time_constant_ff <= PWDATA[TC_W-1:0];
         if (wr_num) num_ff <= PWDATA[RATIO_W-1:0];
         if (wr_den) den_ff <= PWDATA[RATIO_W-1:0];
         if (wr_lim) limit_ff <= PWDATA;
         pending_ff <= set_pend || (pending_ff && !start_div);
      end
   end

   // Active settings: sampled at start, direction on restart; bypass applied at start, pulses and gain when conversion completes
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_ff      <= LATCH_IDLE;
         dir_act_ff    <= RST_DIR;
         pulses_act_ff <= 32'sh0;
         gain_act_ff   <= '0;
         bypass_act_ff <= 1'b1;
         skip_ff       <= 1'b0;
         amt_neg_ff    <= 1'b0;
         amt_skip_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (restart) dir_act_ff <= backlash_direction_select_ff;
         if (start_div) begin
            amt_neg_ff  <= backlash_offset_amount_ff[AMOUNT_W-1];
            amt_skip_ff <= over_limit;
            bypass_act_ff <= backlash_lag_time_constant_ff == '0;
         end
         if (state_ff == LATCH_WAIT && conv_done) begin
            pulses_act_ff <= amt_skip_ff ? 32'sh0 : nxt_pulses;
            skip_ff       <= amt_skip_ff;
            gain_act_ff   <= gain_q;
         end
      end
   end

   // First-order lag in Q24 toward the target offset
   wire signed [55:0] tgt_q   = 56'(target_ff) <<< FRAC_W;
   wire signed [55:0] err_q   = tgt_q - lag_ff;
   wire signed [96:0] step_w  = 97'(err_q) * $signed({1'b0, gain_act_ff});
   wire signed [55:0] step_q  = 56'(step_w >>> FRAC_W);
   // Tiny gain could stall short of the target; force at least one LSB
   wire signed [55:0] step_m  = (step_q == 56'sh0 && err_q != 56'sh0)
                                ? (err_q[55] ? -56'sh1 : 56'sh1) : step_q;
   wire signed [55:0] nxt_lag = bypass_act_ff ? tgt_q : lag_ff + step_m;
   wire signed [31:0] lag_int = 32'(lag_ff >>> FRAC_W);
   wire signed [31:0] ref_now = REF_VALID ? REF_POS : last_ref_ff;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         last_ref_ff <= 32'sh0;
         target_ff   <= 32'sh0;
         lag_ff      <= 56'sh0;
         cmd_ff      <= 32'sh0;
      end else begin
         if (REF_VALID) last_ref_ff <= REF_POS;
         if (!enabled || restart) target_ff <= 32'sh0;
         else if (comp_dir_move) target_ff <= pulses_act_ff;
         else if (opp_dir_move) target_ff <= 32'sh0;
         lag_ff <= restart ? 56'sh0 : nxt_lag;
         cmd_ff <= ref_now + lag_int;
      end
   end

   // Read data is captured in the setup phase, so access needs no wait
   wire [31:0] status_word = {27'h0, conv_busy, (target_ff != 32'sh0),
                              skip_ff, pending_ff, dir_act_ff};
   wire [31:0] rd_mux = hit_ctrl ? {31'h0, backlash_direction_select_ff}
                      : hit_amt  ? 32'(backlash_offset_amount_ff)
                      : hit_tc   ? 32'(backlash_lag_time_constant_ff)
                      : hit_num  ? 32'(num_ff)
                      : hit_den  ? 32'(den_ff)
                      : hit_lim  ? limit_ff
                      : hit_st   ? status_word
                      : hit_comp ? lag_int
                      : 32'h0;

   always_ff @(posedge CLK) begin
      if (RESET) prdata_ff <= 32'h0;
      else if (setup_rd) prdata_ff <= rd_mux;
   end

   assign PRDATA      = prdata_ff;
   assign PREADY      = 1'b1;
   assign PSLVERR     = PSEL && PENABLE && !mapped;
   assign CMD_POS     = cmd_ff;
   assign COMP_ACTIVE = target_ff != 32'sh0;
endmodule // backlash_compensation_adder

// ==== include/backlash_pkg.sv ====
// Purpose: Shared constants for the backlash compensation adder.
// Assumes: 10 MHz CLK, APB register access, 32-bit data.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package backlash_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_AMOUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_LAG_TC = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_NUM    = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_DEN    = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_LIMIT  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_COMP   = 8'h1c;
   // CTRL fields
   localparam int unsigned CTRL_DIR_BIT     = 0;
   localparam int unsigned CTRL_RESTART_BIT = 31;
   // STATUS fields
   localparam int unsigned ST_DIR_BIT     = 0;
   localparam int unsigned ST_PENDING_BIT = 1;
   localparam int unsigned ST_SKIP_BIT    = 2;
   localparam int unsigned ST_ACTIVE_BIT  = 3;
   localparam int unsigned ST_BUSY_BIT    = 4;
   // Widths and ranges
   localparam int unsigned AMOUNT_W = 20;
   localparam int signed   AMOUNT_MAX = 500000;
   localparam int signed   AMOUNT_MIN = -500000;
   localparam int unsigned TC_W    = 16;
   localparam int unsigned RATIO_W = 16;
   localparam int unsigned DIV_W   = 40;
   localparam int unsigned FRAC_W  = 24;
   // Reset values
   localparam logic                 RST_DIR    = 1'b0;
   localparam logic [AMOUNT_W-1:0]  RST_AMOUNT = 20'h00000;
   localparam logic [TC_W-1:0]      RST_TC     = 16'h0000;
   localparam logic [RATIO_W-1:0]   RST_NUM    = 16'h0001;
   localparam logic [RATIO_W-1:0]   RST_DEN    = 16'h0001;
   localparam logic [31:0]          RST_LIMIT  = 32'h0007a120;
   // Timing: one time-constant step is 0.01 ms
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TC_STEP_NS    = 10000;
   localparam int unsigned CYC_PER_TC    = TC_STEP_NS / CLK_PERIOD_NS;
   // Amount is held in tenths of a reference unit
   localparam int unsigned TENTHS_PER_UNIT = 10;
   typedef enum logic [1:0] {
      LATCH_IDLE  = 2'b00,
      LATCH_START = 2'b01,
      LATCH_WAIT  = 2'b10
   } latch_state_e;
endpackage

// ==== core/backlash_divider.sv ====
// Purpose: Sequential unsigned restoring divider, one quotient bit per cycle.
// Assumes: start is a one-cycle pulse while not busy.
// Notes:   Divide by zero yields all ones; quotient truncates toward zero.
`timescale 1ns/1ps
module backlash_divider #(
   parameter int unsigned WIDTH = 40
) (
   input  wire logic             CLK,
   input  wire logic             RESET,
   input  wire logic             START,
   input  wire logic [WIDTH-1:0] DIVIDEND,
   input  wire logic [WIDTH-1:0] DIVISOR,
   output logic                  BUSY,
   output logic                  DONE,
   output logic      [WIDTH-1:0] QUOTIENT
);
   localparam int unsigned CNT_W = $clog2(WIDTH + 1);
   logic [WIDTH-1:0] rem_ff;
   logic [WIDTH-1:0] quo_ff;
   logic [WIDTH-1:0] dsr_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic             busy_ff;
   logic             done_ff;
   wire  [WIDTH:0]   shifted = {rem_ff, quo_ff[WIDTH-1]};
   wire              fits    = shifted >= {1'b0, dsr_ff};
   wire  [WIDTH:0]   reduced = shifted - {1'b0, dsr_ff};
   wire  [WIDTH-1:0] nxt_rem = fits ? reduced[WIDTH-1:0] : shifted[WIDTH-1:0];

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rem_ff  <= '0;
         quo_ff  <= '0;
         dsr_ff  <= '0;
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (START && !busy_ff) begin
            rem_ff  <= '0;
            quo_ff  <= DIVIDEND;
            dsr_ff  <= DIVISOR;
            cnt_ff  <= CNT_W'(WIDTH);
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            rem_ff <= nxt_rem;
            quo_ff <= {quo_ff[WIDTH-2:0], fits};
            cnt_ff <= cnt_ff - 1'b1;
            if (cnt_ff == CNT_W'(1)) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end
         end
      end
   end

   assign BUSY     = busy_ff;
   assign DONE     = done_ff;
   assign QUOTIENT = quo_ff;
endmodule // backlash_divider

// ==== testbench/backlash_checker.sv ====
// Purpose: Port-level assertions for the backlash compensation adder.
// Assumes: One CLK domain, RESET synchronous and active high.
// Notes:   Sees the top-level ports only; bound at the foot of this file.
`timescale 1ns/1ps
module backlash_checker
   import backlash_pkg::*;
(
   input wire logic                            CLK,
   input wire logic                            RESET,
   input wire logic                            PSEL,
   input wire logic                            PENABLE,
   input wire logic [backlash_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0]                     PRDATA,
   input wire logic                            PREADY,
   input wire logic                            PSLVERR,
   input wire logic                            POS_CONTROL_MODE,
   input wire logic                            ROTARY_MOTOR,
   input wire logic                            SERVO_ON,
   input wire logic signed [31:0]              CMD_POS,
   input wire logic                            COMP_ACTIVE
);
   wire en;
   assign en = POS_CONTROL_MODE && ROTARY_MOTOR && SERVO_ON;
   default clocking @(posedge CLK); endclocking
   default disable iff (RESET);
   chk_ready_high: assert property (PREADY)
      else $error("ready dropped");
   chk_err_unmapped: assert property (PSEL && PENABLE && PADDR > 8'h1c |-> PSLVERR)
      else $error("no error on unmapped address");
   chk_err_mapped: assert property (PSEL && PENABLE && PADDR <= 8'h1c && PADDR[1:0] == 2'h0
                                    |-> !PSLVERR)
      else $error("error on mapped address");
   chk_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
      else $error("error outside access phase");
   chk_rdata_hold: assert property (!(PSEL && !PENABLE) |=> $stable(PRDATA))
      else $error("read data moved without setup");
   chk_gate_off: assert property ((!en)[*2] |-> !COMP_ACTIVE)
      else $error("offset held while compensation disabled");
   chk_rise_enabled: assert property ($rose(COMP_ACTIVE) |-> $past(en))
      else $error("offset armed while disabled");
   chk_reset_clear: assert property ($fell(RESET) |-> CMD_POS == 32'sh0 && !COMP_ACTIVE)
      else $error("outputs not cleared by reset");
   cov_offset: cover property (en && COMP_ACTIVE);
   cov_unmapped: cover property (PSEL && PENABLE && PSLVERR);
   cov_release: cover property ($fell(RESET));
endmodule // backlash_checker

bind backlash_compensation_adder backlash_checker chk (
   .CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
   .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .POS_CONTROL_MODE(POS_CONTROL_MODE),
   .ROTARY_MOTOR(ROTARY_MOTOR), .SERVO_ON(SERVO_ON), .CMD_POS(CMD_POS),
   .COMP_ACTIVE(COMP_ACTIVE));

// ==== testbench/ref_host_model.sv ====
// Purpose: Host and motor stand-in that issues position references.
// Assumes: MOVE_REQ is a one-cycle pulse.
// Notes:   Motor reports motion for SETTLE cycles, so slow moves block the latch.
`timescale 1ns/1ps
module ref_host_model (
   input  wire logic               CLK,
   input  wire logic               MOVE_REQ,
   input  wire logic signed [31:0] MOVE_TO,
   input  wire logic [7:0]         SETTLE,
   output logic                    REF_VALID,
   output logic signed [31:0]      REF_POS,
   output logic                    MOTOR_STOPPED
);
   logic [7:0] left_ff = 8'h00;
   initial begin
      REF_VALID = 1'b0;
      REF_POS = 32'sh0;
      MOTOR_STOPPED = 1'b1;
   end
   always @(posedge CLK) begin
      REF_VALID <= MOVE_REQ;
      if (MOVE_REQ)
         REF_POS <= MOVE_TO;
      left_ff <= MOVE_REQ ? SETTLE : left_ff - 8'(left_ff != 8'h00);
      MOTOR_STOPPED <= !MOVE_REQ && left_ff <= 8'h01;
   end
endmodule // ref_host_model

// ==== testbench/backlash_compensation_adder_tb.sv ====
// Purpose: Self-checking bench for the backlash compensation adder.
// Assumes: Zero-wait APB slave; the host model makes the references.
// Notes:   Waits of 60 cycles at rest let staged settings take over.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module backlash_compensation_adder_tb;
   import backlash_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, settle = 8'h02;
   logic [31:0] pwdata = 32'h0, prdata, e;
   logic pready, pslverr, stopped, ref_valid, comp_active, move_req = 1'b0;
   logic mode = 1'b0, rot = 1'b0, servo = 1'b0;
   logic signed [31:0] ref_pos, cmd_pos, move_to = 32'sh0, pos = 32'sh0;
   logic [1:0] probe = 2'd0;
   logic [31:0] exp_q[$];
   int mismatches = 0, checks = 0, cyc = 0;
   always #50 clk = ~clk;
   backlash_compensation_adder uut (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .POS_CONTROL_MODE(mode), .ROTARY_MOTOR(rot), .SERVO_ON(servo),
      .MOTOR_STOPPED(stopped), .REF_VALID(ref_valid), .REF_POS(ref_pos),
      .CMD_POS(cmd_pos), .COMP_ACTIVE(comp_active));
   ref_host_model host (.CLK(clk), .MOVE_REQ(move_req), .MOVE_TO(move_to),
      .SETTLE(settle), .REF_VALID(ref_valid), .REF_POS(ref_pos), .MOTOR_STOPPED(stopped));
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end
   always @(posedge clk) begin
      if ((psel && penable && !pwrite) || probe != 2'd0)
         e = exp_q.pop_front();
      if (psel && penable && !pwrite)
         `CHK(prdata, e)
      if (probe == 2'd1)
         `CHK(cmd_pos, e)
      if (probe == 2'd2)
         `CHK(32'(cmd_pos > ref_pos && cmd_pos - ref_pos < e), 32'h1)
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      if (!w)
         exp_q.push_back(d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= w ? d : 32'h0;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic look(input logic [31:0] v, input logic [1:0] m);
      exp_q.push_back(v);
      probe <= m;
      @(posedge clk) probe <= 2'd0;
   endtask
   // Offset seen 40 cycles after the reference, long after its 3-cycle path
   task automatic move(input logic signed [31:0] dlt, input logic signed [31:0] off,
                       input logic [7:0] s, input logic [1:0] m);
      pos = pos + dlt;
      move_req <= 1'b1;
      move_to <= pos;
      settle <= s;
      @(posedge clk) move_req <= 1'b0;
      repeat (40) @(posedge clk);
      // The lag probe compares against the offset bound, not a position
      look(m == 2'd2 ? off : pos + off, m);
   endtask
   function automatic logic signed [31:0] rnd();
      return 32'($urandom_range(1, 5000));
   endfunction
   initial begin
      logic [31:0] rv [6];
      rv = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h1, 32'h7a120};
      void'($urandom(23697));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) apb(1'b0, 8'(4 * i), rv[i]);
      apb(1'b1, OFF_AMOUNT, 32'h10000);
      apb(1'b1, OFF_AMOUNT, 32'd500001);
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b0, OFF_AMOUNT, 32'h10000);
      repeat (60) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         {mode, rot, servo} <= 3'(k);
         move(rnd(), k == 7 ? 32'sd6553 : 32'sd0, 8'd4, 2'd1);
      end
      move(-rnd(), 0, 8'd4, 2'd1);
      apb(1'b1, OFF_NUM, 32'h3);
      apb(1'b1, OFF_DEN, 32'h2);
      apb(1'b1, OFF_NUM, 32'h0);
      apb(1'b0, OFF_NUM, 32'h3);
      apb(1'b1, OFF_AMOUNT, 32'hffff0000);
      apb(1'b0, OFF_AMOUNT, 32'hffff0000);
      // Writes landing mid-conversion queue a second run, so wait for both
      repeat (120) @(posedge clk);
      move(rnd(), -32'sd9830, 8'd4, 2'd1);
      move(rnd(), -32'sd9830, 8'd200, 2'd1);
      apb(1'b1, OFF_AMOUNT, 32'h10000);
      move(rnd(), -32'sd9830, 8'd200, 2'd1);
      repeat (300) @(posedge clk);
      move(rnd(), 32'sd9830, 8'd4, 2'd1);
      apb(1'b1, OFF_LIMIT, 32'd1000);
      repeat (60) @(posedge clk);
      move(rnd(), 0, 8'd4, 2'd1);
      apb(1'b1, OFF_LIMIT, 32'h7a120);
      // Restart copies the direction staged before its own write
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h80000001);
      apb(1'b0, OFF_CTRL, 32'h1);
      repeat (60) @(posedge clk);
      move(rnd(), 0, 8'd4, 2'd1);
      move(-rnd(), 32'sd9830, 8'd4, 2'd1);
      move(rnd(), 0, 8'd4, 2'd1);
      apb(1'b1, OFF_LAG_TC, 32'h1);
      repeat (60) @(posedge clk);
      move(-rnd(), 32'sd9830, 8'd4, 2'd2);
      repeat (5000) @(posedge clk);
      look(pos + 32'sd9830, 2'd1);
      end_sim();
   end
endmodule // backlash_compensation_adder_tb
